/* File: shared/spc_pkg.sv */
/*
  Constants for the serial peripheral port: register addresses, bit
  positions, masks, reset values, transfer lengths and sequencer states.
  Assumes it is compiled before any design file that imports it.
*/
package spc_pkg;

  // register bus shape
  localparam int unsigned SPC_ADDR_W = 3;
  localparam int unsigned SPC_DATA_W = 8;

  // register addresses
  localparam logic [SPC_ADDR_W-1:0] SPC_REG_CTRL1 = 3'h0;
  localparam logic [SPC_ADDR_W-1:0] SPC_REG_CTRL2 = 3'h1;
  localparam logic [SPC_ADDR_W-1:0] SPC_REG_BAUD = 3'h2;
  localparam logic [SPC_ADDR_W-1:0] SPC_REG_STATUS = 3'h3;
  localparam logic [SPC_ADDR_W-1:0] SPC_REG_DATA_HI = 3'h4;
  localparam logic [SPC_ADDR_W-1:0] SPC_REG_DATA_LO = 3'h5;

  // serial_port_control_one bit positions
  localparam int unsigned SPC_C1_RX_FAULT_IRQ_EN = 7;
  localparam int unsigned SPC_C1_SYSTEM_EN = 6;
  localparam int unsigned SPC_C1_TX_EMPTY_IRQ_EN = 5;
  localparam int unsigned SPC_C1_MASTER_SELECT = 4;
  localparam int unsigned SPC_C1_CLOCK_POLARITY = 3;
  localparam int unsigned SPC_C1_CLOCK_PHASE = 2;
  localparam int unsigned SPC_C1_SELECT_OUT_EN = 1;
  localparam int unsigned SPC_C1_LOW_BIT_FIRST = 0;

  // serial_port_control_two bit positions and implemented bits
  localparam int unsigned SPC_C2_WIDE_MODE = 7;
  localparam int unsigned SPC_C2_MODE_FAULT_EN = 4;
  localparam int unsigned SPC_C2_BIDIR_OUT_EN = 3;
  localparam int unsigned SPC_C2_BIDIR_MODE = 0;
  localparam logic [SPC_DATA_W-1:0] SPC_C2_MASK = 8'h99;

  // baud register fields
  localparam int unsigned SPC_BR_PRESCALE_LSB = 4;
  localparam int unsigned SPC_BR_RATE_LSB = 0;
  localparam int unsigned SPC_BR_FIELD_W = 3;
  localparam logic [SPC_DATA_W-1:0] SPC_BR_MASK = 8'h77;

  // port_status_register bit positions
  localparam int unsigned SPC_ST_RX_FULL = 7;
  localparam int unsigned SPC_ST_TX_EMPTY = 5;
  localparam int unsigned SPC_ST_MODE_FAULT = 4;

  // reset values
  localparam logic [SPC_DATA_W-1:0] SPC_CTRL1_RST = 8'h00;
  localparam logic [SPC_DATA_W-1:0] SPC_CTRL2_RST = 8'h00;
  localparam logic [SPC_DATA_W-1:0] SPC_BAUD_RST = 8'h00;

  // transfer lengths in bits
  localparam logic [4:0] SPC_BITS_NARROW = 5'h08;
  localparam logic [4:0] SPC_BITS_WIDE = 5'h10;

  // half-period counter width
  localparam int unsigned SPC_DIV_W = 12;

  // transfer sequencer, gray coded along idle -> run -> finish
  typedef enum logic [1:0] {
    SPC_IDLE = 2'b00,
    SPC_RUN = 2'b01,
    SPC_FINISH = 2'b11
  } spc_state_t;

endpackage : spc_pkg

/* File: design/spc_port.sv */
/*
  Serial peripheral port: control registers, baud divider, master and
  slave transfer sequencer, shifter and pin steering for clock, two data
  pins and the select pin.
  Assumes one 40 MHz clock, a synchronous active-high reset, a plain
  register port, and a pad ring that resolves pins from the active-low
  output enables.
*/
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

module spc_port
  import spc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [SPC_ADDR_W-1:0] regAddr,
  input wire logic [SPC_DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [SPC_DATA_W-1:0] regRdData,
  output logic irqReq,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOeN,
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOeN,
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOeN,
  input wire logic ssIn,
  output logic ssOut,
  output logic ssOeN
);

  logic [SPC_DATA_W-1:0] ctrl1Q;
  logic [SPC_DATA_W-1:0] ctrl2Q;
  logic [SPC_DATA_W-1:0] baudQ;
  logic [15:0] txBufQ;
  logic [15:0] rxBufQ;
  logic [15:0] shQ;
  logic [15:0] shiftD;
  logic txEmptyQ;
  logic rxFullQ;
  logic modeFaultQ;
  logic outBitQ;
  logic [4:0] sampCntQ;
  logic [5:0] edgeCntQ;
  logic [SPC_DIV_W-1:0] divCntQ;
  logic sckLvlQ;
  spc_state_t stateQ;
  spc_state_t stateD;

  // pin synchronisers: order is sck, mosi, miso, ss
  logic [3:0] pinS1Q;
  logic [3:0] pinS2Q;
  logic sckS3Q;
  logic ssS3Q;

  // decoded control fields
  logic portEn, isMaster, clock_polarity, clock_phase, lsbFirst, select_output_enable;
  logic wide, mode_fault_enable, bidir, bidirOe, rxIe, txIe;
  assign portEn = ctrl1Q[SPC_C1_SYSTEM_EN];
  assign isMaster = ctrl1Q[SPC_C1_MASTER_SELECT];
  assign clock_polarity = ctrl1Q[SPC_C1_CLOCK_POLARITY];
  assign clock_phase = ctrl1Q[SPC_C1_CLOCK_PHASE];
  assign lsbFirst = ctrl1Q[SPC_C1_LOW_BIT_FIRST];
  assign select_output_enable = ctrl1Q[SPC_C1_SELECT_OUT_EN];
  assign rxIe = ctrl1Q[SPC_C1_RX_FAULT_IRQ_EN];
  assign txIe = ctrl1Q[SPC_C1_TX_EMPTY_IRQ_EN];
  assign wide = ctrl2Q[SPC_C2_WIDE_MODE];
  assign mode_fault_enable = ctrl2Q[SPC_C2_MODE_FAULT_EN];
  assign bidir = ctrl2Q[SPC_C2_BIDIR_MODE];
  assign bidirOe = ctrl2Q[SPC_C2_BIDIR_OUT_EN];

  // synchronised pin levels
  logic sckS, mosiS, misoS, ssS;
  assign sckS = pinS2Q[3];
  assign mosiS = pinS2Q[2];
  assign misoS = pinS2Q[1];
  assign ssS = pinS2Q[0];

  // register strobes
  logic wrCtrl1, wrCtrl2, wrBaud, wrStatus, wrDataHi, wrDataLo, rdDataLo;
  assign wrCtrl1 = regWrEn && (regAddr == SPC_REG_CTRL1);
  assign wrCtrl2 = regWrEn && (regAddr == SPC_REG_CTRL2);
  assign wrBaud = regWrEn && (regAddr == SPC_REG_BAUD);
  assign wrStatus = regWrEn && (regAddr == SPC_REG_STATUS);
  assign wrDataHi = regWrEn && (regAddr == SPC_REG_DATA_HI);
  assign wrDataLo = regWrEn && (regAddr == SPC_REG_DATA_LO);
  assign rdDataLo = regRdEn && (regAddr == SPC_REG_DATA_LO);

  // select pin role
  logic autoSs, faultSense;
  assign autoSs = isMaster && mode_fault_enable && select_output_enable;
  assign faultSense = isMaster && mode_fault_enable && !select_output_enable;

  // serial input pick per role and wiring
  logic inBit;
  assign inBit = isMaster ? (bidir ? mosiS : misoS)
                          : (bidir ? misoS : mosiS);

  // transfer length
  logic [4:0] nBits;
  assign nBits = wide ? SPC_BITS_WIDE : SPC_BITS_NARROW;

  // half period = divisor / 2 = (prescale+1) << rate
  logic [SPC_DIV_W-1:0] halfLen;
  logic [3:0] preP1;
  logic [SPC_BR_FIELD_W-1:0] rateSel;
  assign preP1 = {1'b0, baudQ[SPC_BR_PRESCALE_LSB +: SPC_BR_FIELD_W]} + 4'h1;
  assign rateSel = baudQ[SPC_BR_RATE_LSB +: SPC_BR_FIELD_W];
  assign halfLen = SPC_DIV_W'(preP1) << rateSel;

  logic running, tick;
  assign running = (stateQ != SPC_IDLE);
  assign tick = running && isMaster && (divCntQ == halfLen - 12'h001);

  // clock edges normalised against polarity; lead leaves idle level
  logic normNow, normPrev, slaveSel, slaveLead, slaveTrail, ssFall;
  assign normNow = sckS ^ clock_polarity;
  assign normPrev = sckS3Q ^ clock_polarity;
  assign slaveSel = portEn && !isMaster && !ssS;
  assign slaveLead = slaveSel && normNow && !normPrev;
  assign slaveTrail = slaveSel && !normNow && normPrev;
  assign ssFall = !ssS && ssS3Q;

  logic leadEv, trailEv, sampleEv, driveEv;
  assign leadEv = isMaster ? (stateQ == SPC_RUN && tick && !edgeCntQ[0])
                           : (stateQ == SPC_RUN && slaveLead);
  assign trailEv = isMaster ? (stateQ == SPC_RUN && tick && edgeCntQ[0])
                            : (stateQ == SPC_RUN && slaveTrail);
  assign sampleEv = clock_phase ? trailEv : leadEv;
  assign driveEv = clock_phase ? leadEv : trailEv;

  // starts, faults and completion
  logic startM, startS, start, modeFault, doneEv, lastEdge;
  assign startM = portEn && isMaster && (stateQ == SPC_IDLE) &&
                  !txEmptyQ && !wrDataLo;
  assign startS = portEn && !isMaster && (stateQ == SPC_IDLE) && ssFall;
  assign start = startM || startS;
  assign modeFault = portEn && faultSense && !ssS;
  assign doneEv = sampleEv && (sampCntQ == nBits - 5'h01) && !modeFault;
  assign lastEdge = tick && (edgeCntQ == {nBits, 1'b0} - 6'h01);

  // one serial bit into the shifter in the chosen order
  function automatic logic [15:0] shiftIn(input logic [15:0] sh,
                                          input logic b,
                                          input logic lsbF,
                                          input logic wd);
    logic [15:0] r;
    r = sh;
    if (!lsbF) begin
      r = {sh[14:0], b};
    end else if (wd) begin
      r = {b, sh[15:1]};
    end else begin
      r = {8'h00, b, sh[7:1]};
    end
    return r;
  endfunction : shiftIn

  // bit that goes on the wire next
  function automatic logic topBit(input logic [15:0] sh,
                                  input logic lsbF,
                                  input logic wd);
    logic r;
    r = lsbF ? sh[0] : (wd ? sh[15] : sh[7]);
    return r;
  endfunction : topBit

  assign shiftD = shiftIn(shQ, inBit, lsbFirst, wide);

  // pin synchronisers, first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pinS1Q <= 4'hF;
      pinS2Q <= 4'hF;
      sckS3Q <= 1'b1;
      ssS3Q <= 1'b1;
    end else begin
      pinS1Q <= {sckIn, mosiIn, misoIn, ssIn};
      pinS2Q <= pinS1Q;
      sckS3Q <= pinS2Q[3];
      ssS3Q <= pinS2Q[0];
    end
  end

  // control registers; a mode fault drops the port back to slave
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl1Q <= SPC_CTRL1_RST;
      ctrl2Q <= SPC_CTRL2_RST;
      baudQ <= SPC_BAUD_RST;
    end else begin
      if (wrCtrl1) begin
        ctrl1Q <= regWrData;
      end
      if (modeFault) begin
        ctrl1Q[SPC_C1_MASTER_SELECT] <= 1'b0;
      end
      if (wrCtrl2) begin
        ctrl2Q <= regWrData & SPC_C2_MASK;
      end
      if (wrBaud) begin
        baudQ <= regWrData & SPC_BR_MASK;
      end
    end
  end

  // transmit buffer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      txBufQ <= 16'h0000;
    end else begin
      if (wrDataHi) begin
        txBufQ[15:8] <= regWrData;
      end
      if (wrDataLo) begin
        txBufQ[7:0] <= regWrData;
      end
    end
  end

  // sequencer next state
  always_comb begin
    stateD = stateQ;
    case (stateQ)
      SPC_IDLE: begin
        if (start) begin
          stateD = SPC_RUN;
        end
      end
      SPC_RUN: begin
        if (modeFault) begin
          stateD = SPC_IDLE;
        end else if (isMaster && lastEdge) begin
          stateD = SPC_FINISH;
        end else if (!isMaster && (ssS || doneEv)) begin
          stateD = SPC_IDLE;
        end
      end
      SPC_FINISH: begin
        if (tick || !isMaster) begin
          stateD = SPC_IDLE;
        end
      end
      default: begin
        stateD = SPC_IDLE;
      end
    endcase
  end

  // sequencer state; disable forces idle
  always_ff @(posedge clk_sys) begin
    if (srst || !portEn) begin
      stateQ <= SPC_IDLE;
    end else begin
      stateQ <= stateD;
    end
  end

  // half-period divider, restarts with each transfer
  always_ff @(posedge clk_sys) begin
    if (srst || !running || !isMaster || tick) begin
      divCntQ <= '0;
    end else begin
      divCntQ <= divCntQ + 12'h001;
    end
  end

  // master clock level and edge count
  always_ff @(posedge clk_sys) begin
    if (srst || !running || !isMaster) begin
      sckLvlQ <= 1'b0;
      edgeCntQ <= 6'h00;
    end else if (tick && stateQ == SPC_RUN) begin
      sckLvlQ <= !sckLvlQ;
      edgeCntQ <= edgeCntQ + 6'h01;
    end
  end

  // shifter: load at start, sample and drive on the phase's edges
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      shQ <= 16'h0000;
      sampCntQ <= 5'h00;
      outBitQ <= 1'b0;
    end else if (start) begin
      shQ <= txBufQ;
      sampCntQ <= 5'h00;
      if (!clock_phase) begin
        outBitQ <= topBit(txBufQ, lsbFirst, wide);
      end
    end else if (sampleEv) begin
      shQ <= shiftD;
      sampCntQ <= sampCntQ + 5'h01;
    end else if (driveEv) begin
      outBitQ <= topBit(shQ, lsbFirst, wide);
    end
  end

  // receive buffer, high bit stays at the top whatever the order
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rxBufQ <= 16'h0000;
    end else if (doneEv) begin
      rxBufQ <= shiftD;
    end
  end

  // status flags; hardware set wins over software clear
  always_ff @(posedge clk_sys) begin
    if (srst || !portEn) begin
      txEmptyQ <= 1'b1;
      rxFullQ <= 1'b0;
      modeFaultQ <= 1'b0;
    end else begin
      if (start) begin
        txEmptyQ <= 1'b1;
      end else if (wrDataLo) begin
        txEmptyQ <= 1'b0;
      end
      if (doneEv) begin
        rxFullQ <= 1'b1;
      end else if (rdDataLo) begin
        rxFullQ <= 1'b0;
      end
      if (modeFault) begin
        modeFaultQ <= 1'b1;
      end else if (wrStatus && regWrData[SPC_ST_MODE_FAULT]) begin
        modeFaultQ <= 1'b0;
      end
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (srst || !regRdEn) begin
      regRdData <= '0;
    end else begin
      case (regAddr)
        SPC_REG_CTRL1: regRdData <= ctrl1Q;
        SPC_REG_CTRL2: regRdData <= ctrl2Q & SPC_C2_MASK;
        SPC_REG_BAUD: regRdData <= baudQ;
        SPC_REG_STATUS: begin
          regRdData <= '0;
          regRdData[SPC_ST_RX_FULL] <= rxFullQ;
          regRdData[SPC_ST_TX_EMPTY] <= txEmptyQ;
          regRdData[SPC_ST_MODE_FAULT] <= modeFaultQ;
        end
        SPC_REG_DATA_HI: regRdData <= wide ? rxBufQ[15:8] : 8'h00;
        SPC_REG_DATA_LO: regRdData <= rxBufQ[7:0];
        default: regRdData <= '0;
      endcase
    end
  end

  // interrupt request level
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irqReq <= 1'b0;
    end else begin
      irqReq <= portEn && ((rxIe && (rxFullQ || modeFaultQ)) ||
                           (txIe && txEmptyQ));
    end
  end

  // serial clock pin, driven only by an enabled master
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sckOut <= 1'b0;
      sckOeN <= 1'b1;
    end else begin
      sckOut <= sckLvlQ ^ clock_polarity;
      sckOeN <= !(portEn && isMaster);
    end
  end

  // data pins; in bidirectional mode one pin, direction by control two
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mosiOut <= 1'b0;
      mosiOeN <= 1'b1;
      misoOut <= 1'b0;
      misoOeN <= 1'b1;
    end else begin
      mosiOut <= outBitQ;
      mosiOeN <= !(portEn && isMaster && (!bidir || bidirOe));
      misoOut <= outBitQ;
      misoOeN <= !(slaveSel && (!bidir || bidirOe));
    end
  end

  // select pin: driven only as automatic select, else released
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ssOut <= 1'b1;
      ssOeN <= 1'b1;
    end else begin
      ssOut <= !running;
      ssOeN <= !(portEn && autoSs);
    end
  end

endmodule : spc_port

`default_nettype wire

/* File: dv/spc_port_asserts.sv */
/*
  Checker for the serial port: register port and pin drive timing.
  Assumes it is bound to spc_port and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module spc_port_chk
  import spc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [SPC_ADDR_W-1:0] regAddr,
  input wire logic [SPC_DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [SPC_DATA_W-1:0] regRdData,
  input wire logic irqReq,
  input wire logic sckOut,
  input wire logic sckOeN,
  input wire logic mosiOeN,
  input wire logic misoOeN,
  input wire logic ssOut,
  input wire logic ssOeN
);
  logic [7:0] c1Q;
  logic [7:0] c2Q;
  logic [7:0] bQ;
  logic sckQ;
  logic seenQ;
  logic [11:0] gapQ;
  logic [11:0] halfQ;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // shadow copies of the control writes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      c1Q <= 8'h00;
      c2Q <= 8'h00;
      bQ <= 8'h00;
    end else if (regWrEn) begin
      if (regAddr == SPC_REG_CTRL1) c1Q <= regWrData;
      if (regAddr == SPC_REG_CTRL2) c2Q <= regWrData;
      if (regAddr == SPC_REG_BAUD) bQ <= regWrData;
    end
  end
  // cycles since the last clock change, inside a frame
  always_ff @(posedge clk_sys) begin
    sckQ <= sckOut;
    gapQ <= (sckOut != sckQ) ? 12'h001 : gapQ + 12'h001;
    if (srst || ssOut || ssOeN) seenQ <= 1'b0;
    else if (sckOut != sckQ) seenQ <= 1'b1;
  end
  // half period in bus clocks
  assign halfQ = ({9'h000, bQ[6:4]} + 12'h001) << bQ[2:0];

  rst_out_a: assert property ($fell(srst) |-> sckOeN && mosiOeN
    && misoOeN && ssOeN && !irqReq) else $error("pins not released");
  rd_idle_a: assert property (!regRdEn |=> regRdData == 8'h00)
    else $error("read data outside read slot");
  c2_zero_a: assert property (regRdEn && regAddr == SPC_REG_CTRL2
    |=> (regRdData & ~SPC_C2_MASK) == 8'h00) else $error("ctrl2 bits");
  c1_back_a: assert property (regWrEn && regAddr == SPC_REG_CTRL1
    ##2 regRdEn && regAddr == SPC_REG_CTRL1
    |=> regRdData == $past(regWrData, 3)) else $error("ctrl1 readback");
  sck_idle_a: assert property (!ssOeN && ssOut && $stable(c1Q)
    && c1Q == $past(c1Q, 2) |-> sckOut == c1Q[3]) else $error("idle");
  ss_auto_a: assert property (!ssOeN |-> $past(c1Q[6] && c1Q[4]
    && c1Q[1] && c2Q[4])) else $error("select driven wrongly");
  ss_frame_a: assert property (!ssOeN && sckOut != sckQ
    && $stable(c1Q) && c1Q == $past(c1Q, 2) |-> !ssOut)
    else $error("clock without select");
  sck_half_a: assert property (!ssOeN && !ssOut && seenQ
    && sckOut != sckQ |-> gapQ == halfQ) else $error("bad half period");
  off_rel_a: assert property (!c1Q[6] ##1 !c1Q[6] |-> sckOeN
    && mosiOeN && misoOeN && ssOeN) else $error("disabled but driving");
  slv_mosi_a: assert property ($past(c1Q[6] && !c1Q[4])
    |-> mosiOeN) else $error("slave drives mosi");
  mst_miso_a: assert property ($past(c1Q[6] && c1Q[4] && c2Q[0])
    |-> misoOeN) else $error("master drives miso");
endmodule : spc_port_chk

bind spc_port spc_port_chk chk_u (.clk_sys(clk_sys), .srst(srst),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regRdData(regRdData), .irqReq(irqReq),
  .sckOut(sckOut), .sckOeN(sckOeN), .mosiOeN(mosiOeN),
  .misoOeN(misoOeN), .ssOut(ssOut), .ssOeN(ssOeN));
`default_nettype wire

/* File: dv/spc_slave_model.sv */
/*
  Behavioural external slave: eight-bit shifter, msb first.
  Assumes the bench sets polarity and phase equal to the port's.
*/
`timescale 1ns/1ps
`default_nettype none
module spc_slave_model (
  input wire logic sck,
  input wire logic ss,
  input wire logic mosi,
  input wire logic clock_polarity,
  input wire logic clock_phase,
  input wire logic [7:0] txData,
  output logic miso,
  output logic [7:0] rxData
);
  logic [7:0] shQ;
  initial miso = 1'b0;
  // load on select; first bit out at once
  always @(negedge ss) begin
    shQ = txData;
    miso = txData[7];
  end
  // deselected line shows the inverse of its last value
  always @(posedge ss) miso = ~miso;
  // sample on one edge, drive on the other, same polarity as port
  always @(sck) begin
    if (!ss) begin
      if ((sck ^ clock_polarity) != clock_phase) shQ = {shQ[6:0], mosi};
      else miso = shQ[7];
    end
  end
  assign rxData = shQ;
endmodule : spc_slave_model
`default_nettype wire

/* File: dv/spi_control_and_pin_logic_bench.sv */
/*
  Self-checking bench for spc_port with an external slave model.
  Assumes a 40 MHz clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_control_and_pin_logic_bench;
  import spc_pkg::*;
  localparam logic [7:0] M_TX = 8'h1D;
  localparam logic [7:0] S_TX = 8'h63;
  logic clk_sys, srst, regWrEn, regRdEn, ssDrv, mCpol, mCpha;
  logic sckDrv, mosiDrv;
  logic [2:0] regAddr;
  logic [7:0] regWrData, regRdData, mRx;
  logic irqReq, sckOut, sckOeN, mosiOut, mosiOeN, misoOut, misoOeN;
  logic ssOut, ssOeN, mMiso, sckPin, mosiPin, misoPin, ssPin;
  int errors, checks;
  // pin resolution from the active-low enables
  // released clock and mosi follow the far master's drive
  assign sckPin = sckOeN ? sckDrv : sckOut;
  assign mosiPin = mosiOeN ? mosiDrv : mosiOut;
  assign misoPin = misoOeN ? mMiso : misoOut;
  assign ssPin = ssOeN ? ssDrv : ssOut;
  spc_port dut_u (.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .irqReq(irqReq), .sckIn(sckPin),
    .sckOut(sckOut), .sckOeN(sckOeN), .mosiIn(mosiPin),
    .mosiOut(mosiOut), .mosiOeN(mosiOeN), .misoIn(misoPin),
    .misoOut(misoOut), .misoOeN(misoOeN), .ssIn(ssPin), .ssOut(ssOut),
    .ssOeN(ssOeN));
  spc_slave_model slv_u (.sck(sckPin), .ss(ssPin), .mosi(mosiPin),
    .clock_polarity(mCpol), .clock_phase(mCpha), .txData(M_TX), .miso(mMiso),
    .rxData(mRx));
  // 25 ns clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    #1;
    checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask : rd
  task automatic waitSt(input int b);
    logic [7:0] v;
    for (int i = 0; i < 400; i++) begin
      rd(SPC_REG_STATUS, v);
      if (v[b] === 1'b1) return;
    end
    errors++;
    $display("BAD %0t status wait ran out", $time);
    end_sim();
  endtask : waitSt
  function automatic logic [7:0] rev(input logic [7:0] x);
    for (int i = 0; i < 8; i++) rev[i] = x[7-i];
  endfunction : rev
  // reset values, masked bits, unmapped place
  task automatic t_regs;
    logic [7:0] v;
    logic [2:0] ra[4] = '{SPC_REG_CTRL1, SPC_REG_CTRL2, SPC_REG_BAUD, 3'h6};
    logic [7:0] re[4] = '{8'hFF, SPC_C2_MASK, SPC_BR_MASK, 8'h00};
    for (int i = 0; i < 4; i++) begin
      rd(ra[i], v);
      chk(v, 8'h00);
      wr(ra[i], 8'hFF);
      rd(ra[i], v);
      chk(v, re[i]);
    end
    $display("done regs");
  endtask : t_regs
  // one master byte in the given format
  task automatic xfer(input logic [7:0] c1, input logic [7:0] c2,
    input logic [7:0] br, input logic [7:0] d);
    logic [7:0] v;
    mCpol <= c1[SPC_C1_CLOCK_POLARITY];
    mCpha <= c1[SPC_C1_CLOCK_PHASE];
    wr(SPC_REG_CTRL1, 8'h00);
    wr(SPC_REG_CTRL2, c2);
    wr(SPC_REG_BAUD, br);
    wr(SPC_REG_CTRL1, c1);
    wr(SPC_REG_DATA_LO, d);
    waitSt(SPC_ST_RX_FULL);
    chk(mRx, c1[0] ? rev(d) : d);
    chk({7'h00, irqReq}, {7'h00, c1[7]});
    rd(SPC_REG_DATA_LO, v);
    chk(v, c2[0] ? d : (c1[0] ? rev(M_TX) : M_TX));
    repeat (2) @(posedge clk_sys);
    chk({7'h00, irqReq}, 8'h00);
    $display("done xfer %h", c1);
  endtask : xfer
  // transmit-empty interrupt, select pin left as general I/O
  task automatic t_txirq;
    wr(SPC_REG_CTRL2, 8'h00);
    wr(SPC_REG_CTRL1, 8'h72);
    repeat (3) @(posedge clk_sys);
    chk({7'h00, irqReq}, 8'h01);
    chk({7'h00, ssOeN}, 8'h01);
    wr(SPC_REG_CTRL1, 8'h52);
    repeat (3) @(posedge clk_sys);
    chk({7'h00, irqReq}, 8'h00);
    $display("done txirq");
  endtask : t_txirq
  // select pulled low with fault sensing, then disable
  task automatic t_fault;
    logic [7:0] v;
    wr(SPC_REG_CTRL2, 8'h10);
    wr(SPC_REG_CTRL1, 8'h50);
    ssDrv <= 1'b0;
    waitSt(SPC_ST_MODE_FAULT);
    rd(SPC_REG_CTRL1, v);
    chk(v & 8'h10, 8'h00);
    ssDrv <= 1'b1;
    wr(SPC_REG_CTRL1, 8'h00);
    rd(SPC_REG_STATUS, v);
    chk(v, 8'h20);
    $display("done fault");
  endtask : t_fault
  // sixteen-bit master word through the eight-bit far device
  task automatic t_wide;
    logic [7:0] v;
    mCpol <= 1'b0;
    mCpha <= 1'b0;
    wr(SPC_REG_CTRL1, 8'h00);
    wr(SPC_REG_CTRL2, 8'h90);
    wr(SPC_REG_BAUD, 8'h12);
    wr(SPC_REG_CTRL1, 8'h52);
    wr(SPC_REG_DATA_HI, 8'hB3);
    wr(SPC_REG_DATA_LO, 8'h6C);
    waitSt(SPC_ST_RX_FULL);
    chk(mRx, 8'h6C);
    rd(SPC_REG_DATA_HI, v);
    chk(v, M_TX);
    rd(SPC_REG_DATA_LO, v);
    chk(v, 8'hB3);
    $display("done wide");
  endtask : t_wide
  // far master clocks one byte through the port as slave
  task automatic t_slave;
    logic [7:0] v;
    logic [7:0] got;
    wr(SPC_REG_CTRL1, 8'h00);
    wr(SPC_REG_CTRL2, 8'h00);
    wr(SPC_REG_CTRL1, 8'h40);
    wr(SPC_REG_DATA_LO, 8'h9E);
    ssDrv <= 1'b0;
    got = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      mosiDrv <= S_TX[i];
      repeat (8) @(posedge clk_sys);
      got = {got[6:0], misoPin};
      sckDrv <= 1'b1;
      repeat (8) @(posedge clk_sys);
      sckDrv <= 1'b0;
    end
    repeat (8) @(posedge clk_sys);
    ssDrv <= 1'b1;
    chk(got, 8'h9E);
    rd(SPC_REG_DATA_LO, v);
    chk(v, S_TX);
    $display("done slave");
  endtask : t_slave
  // main sequence
  initial begin
    srst = 1'b1;
    regAddr = 3'h0;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    ssDrv = 1'b1;
    sckDrv = 1'b0;
    mosiDrv = 1'b0;
    mCpol = 1'b0;
    mCpha = 1'b0;
    errors = 0;
    checks = 0;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    t_regs();
    // half periods of four or more cover the pin synchroniser delay
    xfer(8'hD2, 8'h10, 8'h02, 8'hA7);
    xfer(8'h5A, 8'h10, 8'h12, 8'h4B);
    xfer(8'h56, 8'h10, 8'h30, 8'hE1);
    xfer(8'h5F, 8'h10, 8'h21, 8'h36);
    xfer(8'h52, 8'h19, 8'h02, 8'hC5);
    t_wide();
    t_txirq();
    t_fault();
    t_slave();
    end_sim();
  end
endmodule : spi_control_and_pin_logic_bench
`default_nettype wire
